// ==== pgb_pkg.sv ====
// Package for the pin bank: register map, field layout, timing constants
package pgb_pkg;
    localparam int PGB_NUM_PINS = 8;
    localparam int PGB_ADDR_W = 8;
    // Register byte offsets (one per pin, then interrupt registers and the input register)
    localparam logic [7:0] PGB_CFG_BASE = 8'h00;
    localparam logic [7:0] PGB_LVL2_OFS = 8'h20;
    localparam logic [7:0] PGB_LVL2_MASK_OFS = 8'h24;
    localparam logic [7:0] PGB_TOP_OFS = 8'h28;
    localparam logic [7:0] PGB_TOP_MASK_OFS = 8'h2C;
    localparam logic [7:0] PGB_IN_OFS = 8'h30;
    localparam logic [7:0] PGB_CFG_SPAN = 8'h20;
    // Per-pin configuration field positions
    localparam int PGB_F_OUT = 0;
    localparam int PGB_F_IN = 1;
    localparam int PGB_F_DIR = 2;
    localparam int PGB_F_DRV = 3;
    localparam int PGB_F_PU = 4;
    localparam int PGB_F_PD = 5;
    localparam int PGB_F_ALT = 6;
    localparam int PGB_F_EDGE = 8;
    localparam int PGB_F_DBNC = 10;
    // Reset config: input, high impedance, no interrupt
    localparam logic [11:0] PGB_CFG_RESET = 12'h004;
    localparam logic PGB_TOP_MASK_RESET = 1'b1;
    localparam logic [7:0] PGB_LVL2_MASK_RESET = 8'hFF;
    // Edge select encodings
    localparam logic [1:0] PGB_EDGE_NONE = 2'h0;
    localparam logic [1:0] PGB_EDGE_FALL = 2'h1;
    localparam logic [1:0] PGB_EDGE_RISE = 2'h2;
    localparam logic [1:0] PGB_EDGE_BOTH = 2'h3;
    // Debounce times in microseconds for the three nonzero settings
    localparam int PGB_CLK_MHZ = 40;
    localparam int PGB_DBNC_US_1 = 8;
    localparam int PGB_DBNC_US_2 = 16;
    localparam int PGB_DBNC_US_3 = 32;
    localparam int PGB_DBNC_W = 11;
    localparam logic [10:0] PGB_DBNC_CYC_1 = 11'(PGB_DBNC_US_1 * PGB_CLK_MHZ);
    localparam logic [10:0] PGB_DBNC_CYC_2 = 11'(PGB_DBNC_US_2 * PGB_CLK_MHZ);
    localparam logic [10:0] PGB_DBNC_CYC_3 = 11'(PGB_DBNC_US_3 * PGB_CLK_MHZ);
    // Pins with sequencer, clock and source-good alternate functions
    localparam logic [7:0] PGB_SEQ_PINS = 8'h87;
    localparam logic [7:0] PGB_CLK_PINS = 8'h70;
    localparam int PGB_GOOD_PIN = 3;

    typedef struct packed {
        logic [1:0] debounce_sel;
        logic [1:0] edge_select;
        logic rsv;
        logic alt_en;
        logic pulldown_en;
        logic pullup_en;
        logic drive_type;
        logic dir_sel;
        logic in_data;
        logic out_data;
    } pgb_cfg_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] pd;
    } pgb_pad_t;
endpackage

// ==== pgb_pin_bank.sv ====
// Eight-pin general purpose bank with debounce, edge interrupts and APB registers
`timescale 1ns/100ps
`default_nettype none
module pgb_pin_bank
    import pgb_pkg::*;
#(
    parameter int NUM_PINS = PGB_NUM_PINS
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [PGB_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Pins
    input wire logic [NUM_PINS-1:0] PIN_IN,
    output logic [NUM_PINS-1:0] PIN_OUT,
    output logic [NUM_PINS-1:0] PIN_OE_OUT,
    output logic [NUM_PINS-1:0] PULLUP_EN_OUT,
    output logic [NUM_PINS-1:0] PULLDOWN_EN_OUT,
    // Alternate sources and results
    input wire logic [NUM_PINS-1:0] SEQ_LEVEL_IN,
    input wire logic CLK32K_IN,
    output logic SOURCE_GOOD_OUT,
    // Interrupt
    output logic IRQ_OUT,
    output logic IRQ_OUT_N_OUT
);
    pgb_cfg_t cfg [NUM_PINS];
    logic [NUM_PINS-1:0] sync1, sync2, filt, filt_d, in_data;
    logic [NUM_PINS-1:0] pin_edge_flag, lvl2_mask, edge_hit;
    logic [PGB_DBNC_W-1:0] dcnt [NUM_PINS];
    logic pinbank_top_flag, pinbank_top_mask;
    logic clk_s1, clk_s2;
    logic [NUM_PINS-1:0] seq_s1, seq_s2;
    logic access, wr, rd;
    logic [31:0] next_rdata;
    pgb_pad_t next_pad;

    function automatic logic [PGB_DBNC_W-1:0] dbnc_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: dbnc_len = '0;
            2'h1: dbnc_len = PGB_DBNC_CYC_1;
            2'h2: dbnc_len = PGB_DBNC_CYC_2;
            2'h3: dbnc_len = PGB_DBNC_CYC_3;
        endcase
    endfunction

    function automatic logic is_cfg(input logic [PGB_ADDR_W-1:0] a);
        is_cfg = (a < PGB_CFG_SPAN) && (a[1:0] == 2'h0);
    endfunction

    assign access = PSEL_IN && PENABLE_IN;
    assign wr = access && PWRITE_IN;
    assign rd = access && !PWRITE_IN;

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            sync1 <= '0;
            sync2 <= '0;
            seq_s1 <= '0;
            seq_s2 <= '0;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
        end else begin
            sync1 <= PIN_IN;
            sync2 <= sync1;
            seq_s1 <= SEQ_LEVEL_IN;
            seq_s2 <= seq_s1;
            clk_s1 <= CLK32K_IN;
            clk_s2 <= clk_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // Filter: accept a level once it held for the chosen time
            // Filtering runs in every mode, alternate included
            always_ff @(posedge MCLK_IN) begin
                if (SYS_RST_IN) begin
                    dcnt[g] <= '0;
                    filt[g] <= 1'b0;
                end else if (sync2[g] == filt[g]) begin
                    dcnt[g] <= '0;
                end else if (dcnt[g] >= dbnc_len(cfg[g].debounce_sel)) begin
                    filt[g] <= sync2[g];
                    dcnt[g] <= '0;
                end else begin
                    dcnt[g] <= dcnt[g] + 1'b1;
                end
            end
            always_comb begin
                unique case (cfg[g].edge_select)
                    PGB_EDGE_NONE: edge_hit[g] = 1'b0;
                    PGB_EDGE_FALL: edge_hit[g] = filt_d[g] && !filt[g];
                    PGB_EDGE_RISE: edge_hit[g] = !filt_d[g] && filt[g];
                    PGB_EDGE_BOTH: edge_hit[g] = filt_d[g] != filt[g];
                endcase
            end
        end
    endgenerate

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            filt_d <= '0;
            in_data <= '0;
        end else begin
            filt_d <= filt;
            in_data <= sync2;
        end
    end

    // Per-pin configuration registers
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg[i] <= pgb_cfg_t'(PGB_CFG_RESET);
            end
        end else if (wr && is_cfg(PADDR_IN)) begin
            cfg[PADDR_IN[4:2]] <= pgb_cfg_t'(PWDATA_IN[11:0]);
        end
    end

    // Edge flags; set wins over a write-one clear
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pin_edge_flag <= '0;
        end else begin
            pin_edge_flag <= (pin_edge_flag & ~((wr && PADDR_IN == PGB_LVL2_OFS) ? PWDATA_IN[7:0] : 8'h00))
                | (edge_hit & ~lvl2_mask);
        end
    end

    // Top flag follows any pending edge flag
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pinbank_top_flag <= 1'b0;
        end else begin
            pinbank_top_flag <= |pin_edge_flag;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            lvl2_mask <= PGB_LVL2_MASK_RESET;
            pinbank_top_mask <= PGB_TOP_MASK_RESET;
        end else if (wr) begin
            if (PADDR_IN == PGB_LVL2_MASK_OFS) begin
                lvl2_mask <= PWDATA_IN[7:0];
            end
            if (PADDR_IN == PGB_TOP_MASK_OFS) begin
                pinbank_top_mask <= PWDATA_IN[0];
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            IRQ_OUT <= 1'b0;
            IRQ_OUT_N_OUT <= 1'b1;
        end else begin
            IRQ_OUT <= pinbank_top_flag && !pinbank_top_mask;
            IRQ_OUT_N_OUT <= !(pinbank_top_flag && !pinbank_top_mask);
        end
    end

    // Pad drive decode
    always_comb begin
        next_pad = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            logic lvl;
            lvl = cfg[i].out_data;
            // Sequencer pins take the sequencer level
            if (cfg[i].alt_en && PGB_SEQ_PINS[i]) begin
                lvl = seq_s2[i];
            end
            // Clock pins take the 32kHz clock
            if (cfg[i].alt_en && PGB_CLK_PINS[i]) begin
                lvl = clk_s2;
            end
            // Push-pull drives both levels, open-drain only low
            if (!cfg[i].dir_sel) begin
                next_pad.o[i] = cfg[i].drive_type ? lvl : 1'b0;
                next_pad.oe[i] = cfg[i].drive_type ? 1'b1 : !lvl;
            end else begin
                next_pad.pu[i] = cfg[i].pullup_en && !cfg[i].pulldown_en;
                // Pull-down follows the documented bit pattern
                next_pad.pd[i] = cfg[i].pulldown_en && cfg[i].out_data && !cfg[i].pullup_en;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            PIN_OUT <= '0;
            PIN_OE_OUT <= '0;
            PULLUP_EN_OUT <= '0;
            PULLDOWN_EN_OUT <= '0;
            SOURCE_GOOD_OUT <= 1'b0;
        end else begin
            PIN_OUT <= next_pad.o;
            PIN_OE_OUT <= next_pad.oe;
            PULLUP_EN_OUT <= next_pad.pu;
            PULLDOWN_EN_OUT <= next_pad.pd;
            // Debounced level of pin 3 as source-good
            SOURCE_GOOD_OUT <= cfg[PGB_GOOD_PIN].alt_en && cfg[PGB_GOOD_PIN].dir_sel && filt[PGB_GOOD_PIN];
        end
    end

    // APB read mux; unmapped reads return zero with error
    always_comb begin
        next_rdata = '0;
        if (is_cfg(PADDR_IN)) begin
            next_rdata[11:0] = cfg[PADDR_IN[4:2]];
            next_rdata[PGB_F_IN] = in_data[PADDR_IN[4:2]];
        end else if (PADDR_IN == PGB_LVL2_OFS) begin
            next_rdata[7:0] = pin_edge_flag;
        end else if (PADDR_IN == PGB_LVL2_MASK_OFS) begin
            next_rdata[7:0] = lvl2_mask;
        end else if (PADDR_IN == PGB_TOP_OFS) begin
            next_rdata[0] = pinbank_top_flag;
        end else if (PADDR_IN == PGB_TOP_MASK_OFS) begin
            next_rdata[0] = pinbank_top_mask;
        end else if (PADDR_IN == PGB_IN_OFS) begin
            next_rdata[7:0] = in_data;
        end
    end

    // Zero-wait slave: ready is registered from setup so it is high in the first access cycle
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            PRDATA_OUT <= '0;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PRDATA_OUT <= (PSEL_IN && !PWRITE_IN) ? next_rdata : '0;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !(is_cfg(PADDR_IN) || PADDR_IN == PGB_LVL2_OFS
                || PADDR_IN == PGB_LVL2_MASK_OFS || PADDR_IN == PGB_TOP_OFS
                || PADDR_IN == PGB_TOP_MASK_OFS || PADDR_IN == PGB_IN_OFS);
        end
    end

    // Assertions; pin-specific ones watch the pins that scenarios drive
    a_irq_pin_level: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (pinbank_top_flag && !pinbank_top_mask) |=> !IRQ_OUT_N_OUT)
        else $error("interrupt pin not asserted");
    a_irq_pin_clear: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !(pinbank_top_flag && !pinbank_top_mask) |=> IRQ_OUT_N_OUT)
        else $error("interrupt pin asserted without cause");
    a_irq_high: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (pinbank_top_flag && !pinbank_top_mask) |=> IRQ_OUT)
        else $error("interrupt level not asserted");
    a_top_follows_flags: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (|pin_edge_flag) |=> pinbank_top_flag)
        else $error("top flag missing");
    a_top_clear: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !(|pin_edge_flag) |=> !pinbank_top_flag)
        else $error("top flag without edge flag");
    a_edge_sets_flag: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (|(edge_hit & ~lvl2_mask)) |=> (|pin_edge_flag))
        else $error("edge did not set flag");
    a_flag_sticky: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !(wr && PADDR_IN == PGB_LVL2_OFS) |=> ((pin_edge_flag & $past(pin_edge_flag)) == $past(pin_edge_flag)))
        else $error("flag lost without clear");
    a_flag_clear: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (wr && PADDR_IN == PGB_LVL2_OFS && PWDATA_IN[2] && !(edge_hit[2] && !lvl2_mask[2])) |=> !pin_edge_flag[2])
        else $error("flag not cleared");
    a_pushpull_drive: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!cfg[0].dir_sel && cfg[0].drive_type && !cfg[0].alt_en)
        |=> (PIN_OE_OUT[0] && PIN_OUT[0] == $past(cfg[0].out_data)))
        else $error("push-pull drive wrong");
    a_open_drain: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!cfg[0].dir_sel && !cfg[0].drive_type) |=> !PIN_OUT[0])
        else $error("open-drain drove high");
    a_open_drain_release: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!cfg[0].dir_sel && !cfg[0].drive_type && !cfg[0].alt_en) |=> PIN_OE_OUT[0] == !$past(cfg[0].out_data))
        else $error("open-drain enable wrong");
    a_input_no_drive: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        cfg[2].dir_sel |=> !PIN_OE_OUT[2])
        else $error("input pin driven");
    a_output_no_pull: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !cfg[0].dir_sel |=> (!PULLUP_EN_OUT[0] && !PULLDOWN_EN_OUT[0]))
        else $error("pull on output pin");
    a_pullup_select: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (cfg[1].dir_sel && cfg[1].pullup_en && !cfg[1].pulldown_en) |=> PULLUP_EN_OUT[1])
        else $error("pull-up not applied");
    a_pulldown_pattern: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (cfg[1].dir_sel && cfg[1].pulldown_en && cfg[1].out_data && !cfg[1].pullup_en) |=> PULLDOWN_EN_OUT[1])
        else $error("pull-down not applied");
    a_sync_delay: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        ##3 in_data == $past(PIN_IN, 3))
        else $error("input sync depth wrong");
    a_filter_wait: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        $changed(filt[2]) |-> ($past(dcnt[2]) >= dbnc_len($past(cfg[2].debounce_sel))))
        else $error("filter changed early");
    a_seq_level: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (cfg[0].alt_en && !cfg[0].dir_sel && cfg[0].drive_type) |=> PIN_OUT[0] == $past(seq_s2[0]))
        else $error("sequencer level not driven");
    a_clock_pin_drive: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (cfg[4].alt_en && !cfg[4].dir_sel && cfg[4].drive_type) |=> PIN_OUT[4] == $past(clk_s2))
        else $error("clock not driven");
    a_source_good: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (cfg[PGB_GOOD_PIN].alt_en && cfg[PGB_GOOD_PIN].dir_sel) |=> SOURCE_GOOD_OUT == $past(filt[PGB_GOOD_PIN]))
        else $error("source good level wrong");
    a_good_off: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !(cfg[PGB_GOOD_PIN].alt_en && cfg[PGB_GOOD_PIN].dir_sel) |=> !SOURCE_GOOD_OUT)
        else $error("source good outside alternate mode");
    a_apb_ready: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (PSEL_IN && !PENABLE_IN) |=> PREADY_OUT)
        else $error("ready late");
    a_ready_once: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    c_edge_irq: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) $fell(IRQ_OUT_N_OUT));
    c_source_good: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) $rose(SOURCE_GOOD_OUT));
    c_flag_clear: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) $fell(pinbank_top_flag));
    c_clock_out: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) $rose(PIN_OUT[4]));
    c_pulldown: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) $rose(PULLDOWN_EN_OUT[1]));
endmodule
`default_nettype wire

// ==== pgb_board_model.sv ====
// Board model: pad levels from bank drive, pulls, external drivers
`timescale 1ns/100ps
`default_nettype none
module pgb_board_model (
    // Clock
    input wire logic clk_in,
    // Bank side
    input wire logic [7:0] lvl_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pu_in,
    input wire logic [7:0] pd_in,
    // Board side
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] pad_out
);
    logic flip = 1'b0;

    // Undriven line wanders so a stale level never passes
    always_ff @(posedge clk_in) begin
        flip <= ~flip;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_in[i]) pad_out[i] = lvl_in[i];
            else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
            else if (pu_in[i]) pad_out[i] = 1'b1;
            else if (pd_in[i]) pad_out[i] = 1'b0;
            else pad_out[i] = flip;
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the pin bank over APB
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pgb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sgood, irq, irq_n, err;
    logic [7:0] pad, pin_o, pin_oe, pu, pd;
    logic [7:0] seq = 8'h00;
    logic c32 = 1'b0;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    int fail_count = 0;
    int checked = 0;
    int e;
    int cyc;
    logic [31:0] ocfg [4] = '{32'h0000_0009, 32'h0000_0008, 32'h0000_0001, 32'h0000_0000};
    logic [31:0] oexp [4] = '{32'h3, 32'h2, 32'h0, 32'h2};
    logic [31:0] aexp [4] = '{32'h2, 32'h3, 32'h2, 32'h0};
    int apin [3] = '{0, 7, 4};

    always #12.5 clk = ~clk;

    pgb_pin_bank i_dut (
        .MCLK_IN(clk), .SYS_RST_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .PIN_IN(pad), .PIN_OUT(pin_o), .PIN_OE_OUT(pin_oe), .PULLUP_EN_OUT(pu), .PULLDOWN_EN_OUT(pd),
        .SEQ_LEVEL_IN(seq), .CLK32K_IN(c32), .SOURCE_GOOD_OUT(sgood),
        .IRQ_OUT(irq), .IRQ_OUT_N_OUT(irq_n)
    );

    pgb_board_model i_board (
        .clk_in(clk), .lvl_in(pin_o), .oe_in(pin_oe), .pu_in(pu), .pd_in(pd),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pad)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Setup then access, held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, exp, what);
    endtask

    initial begin
        wt(12);
        rst <= 1'b0;
        wt(2);
        chk(32'(irq_n), 32'h1, "irq idle");
        chk(32'(irq), 32'h0, "irq level idle");
        rdc(PGB_CFG_BASE, 32'h0000_0004, 32'hFFFF_FFFF, "cfg reset");
        rdc(PGB_LVL2_MASK_OFS, 32'h0000_00FF, 32'hFFFF_FFFF, "lvl2 mask reset");
        rdc(PGB_TOP_MASK_OFS, 32'h1, 32'hFFFF_FFFF, "top mask reset");
        rdc(PGB_TOP_OFS, 32'h0, 32'hFFFF_FFFF, "top flag reset");
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(32'(err), 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        // Release pads that the bank will drive or pull
        ext_en <= 8'h6C;
        foreach (ocfg[k]) begin
            wr(PGB_CFG_BASE, ocfg[k]);
            wt(2);
            chk(32'({pin_oe[0], pin_o[0]}), oexp[k], "output drive");
            chk(32'({pu[0], pd[0]}), 32'h0, "output pulls");
        end
        for (int k = 0; k < 2; k++) begin
            wr(PGB_CFG_BASE + 8'h04, k ? 32'h0000_0025 : 32'h0000_0014);
            wt(6);
            chk(32'({pu[1], pd[1]}), k ? 32'h1 : 32'h2, "pull select");
            rdc(PGB_IN_OFS, k ? 32'h0 : 32'h2, 32'h2, "pulled level");
        end
        wr(PGB_LVL2_MASK_OFS, 32'h0000_0000);
        wr(PGB_TOP_MASK_OFS, 32'h0000_0000);
        for (int es = 1; es < 4; es++) begin
            wr(PGB_CFG_BASE + 8'h08, 32'h0000_0004 | 32'(es << 8));
            for (int lv = 1; lv >= 0; lv--) begin
                ext_val[2] <= lv[0];
                wt(10);
                e = lv ? (es >> 1) & 1 : es & 1;
                rdc(PGB_LVL2_OFS, 32'(e << 2), 32'hFF, "edge flag");
                chk(32'(irq_n), 32'(e == 0), "irq pin");
                chk(32'(irq), 32'(e != 0), "irq level");
                rdc(PGB_TOP_OFS, 32'(e), 32'h1, "top flag");
                wr(PGB_LVL2_OFS, 32'h0000_00FF);
            end
        end
        ext_val[2] <= 1'b1;
        wt(10);
        wr(PGB_TOP_MASK_OFS, 32'h1);
        wt(3);
        chk(32'(irq_n), 32'h1, "masked irq");
        chk(32'(irq), 32'h0, "masked irq level");
        rdc(PGB_TOP_OFS, 32'h1, 32'h1, "flag held");
        wr(PGB_LVL2_OFS, 32'h0000_0004);
        wt(3);
        rdc(PGB_TOP_OFS, 32'h0, 32'h1, "top follows clear");
        wr(PGB_CFG_BASE + 8'h0C, 32'h0000_0244);
        ext_val[3] <= 1'b1;
        wt(10);
        chk(32'(sgood), 32'h1, "source good high");
        rdc(PGB_LVL2_OFS, 32'h08, 32'h08, "alt edge");
        ext_val[3] <= 1'b0;
        wt(10);
        chk(32'(sgood), 32'h0, "source good low");
        // Shortest nonzero filter; glitch then steady level
        wr(PGB_CFG_BASE + 8'h08, 32'h0000_0604);
        ext_val[2] <= 1'b0;
        wt(400);
        wr(PGB_LVL2_OFS, 32'h0000_00FF);
        ext_val[2] <= 1'b1;
        wt(200);
        ext_val[2] <= 1'b0;
        wt(400);
        rdc(PGB_LVL2_OFS, 32'h0, 32'h04, "glitch filtered");
        ext_val[2] <= 1'b1;
        wt(250);
        rdc(PGB_LVL2_OFS, 32'h0, 32'h04, "early edge");
        wt(100);
        rdc(PGB_LVL2_OFS, 32'h04, 32'h04, "filtered edge");
        // Longer filters: no edge just before the count ends, edge just after
        for (int ds = 2; ds < 4; ds++) begin
            cyc = (ds == 2) ? int'(PGB_DBNC_CYC_2) : int'(PGB_DBNC_CYC_3);
            wr(PGB_CFG_BASE + 8'h08, 32'h0000_0204 | 32'(ds << 10));
            ext_val[2] <= 1'b0;
            wt(cyc + 20);
            wr(PGB_LVL2_OFS, 32'h0000_00FF);
            ext_val[2] <= 1'b1;
            wt(cyc - 20);
            rdc(PGB_LVL2_OFS, 32'h0, 32'h04, "long filter early");
            wt(40);
            rdc(PGB_LVL2_OFS, 32'h04, 32'h04, "long filter edge");
        end
        foreach (apin[j]) begin
            for (int k = 0; k < 4; k++) begin
                wr(PGB_CFG_BASE + 8'(4 * apin[j]), k[1] ? 32'h0000_0040 : 32'h0000_0048);
                seq[apin[j]] <= k[0];
                c32 <= k[0];
                wt(6);
                chk(32'({pin_oe[apin[j]], pin_o[apin[j]]}), aexp[k], "alt drive");
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
